/* File: core/dwa_pkg.sv */
// Shared constants for the DMA width-align and lane-replicate data path
package dwa_pkg;

  // ----------------------------------------------------------------
  // AHB encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // ----------------------------------------------------------------
  // Item width settings (same code as HSIZE low bits)
  // ----------------------------------------------------------------
  localparam logic [1:0] WIDTH_BYTE = 2'h0;
  localparam logic [1:0] WIDTH_HALF = 2'h1;
  localparam logic [1:0] WIDTH_WORD = 2'h2;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int ITEM_CNT_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;

endpackage

/* File: core/dwa_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dwa_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW:0] wr_q, wr_d, rd_q, rd_d;
  logic push, pop;

  // ----------------------------------------------------------------
  // Pointer logic
  // ----------------------------------------------------------------
  // Extra pointer bit separates full from empty
  always_comb begin
    in_ready_o = (wr_q - rd_q) != (PW+1)'(DEPTH);
    out_valid_o = wr_q != rd_q;
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    wr_d = push ? wr_q + (PW+1)'(1) : wr_q;
    rd_d = pop ? rd_q + (PW+1)'(1) : rd_q;
    out_data_o = mem_q[rd_q[PW-1:0]];
  end

  // Pointer registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // Storage has no reset; only valid slots are ever read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q[PW-1:0]] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

/* File: core/dwa_core.sv */
// DMA data path: width conversion, address stepping, AHB master, lane replication
//
// Operation
// - Convert every item between source and destination widths when they differ.
// - Wider destination: item in low bits, upper bits filled with zeros.
// - Narrower destination: write only the low destination-width bits.
// - Both steps enabled: source and destination advance by their own item size.
// - Each item is one source read then one destination write; count in items.
// - Own registers accept only 32-bit accesses; narrower accesses fault.
// - Byte or halfword writes replicate data on all lanes, HSIZE shows real size.
// - An enabled side steps its address by 1, 2 or 4 after each transfer.
// - Peripheral and memory item widths come from two separate settings.
`timescale 1ns/1ps
`default_nettype none
module dwa_core
  import dwa_pkg::*;
#(
  parameter int CNT_W = ITEM_CNT_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Channel settings, sampled at start
  input wire logic [1:0] periph_item_width_i,
  input wire logic [1:0] mem_item_width_i,
  input wire logic periph_addr_step_en_i,
  input wire logic mem_addr_step_en_i,
  input wire logic mem_to_periph_i,
  input wire logic [ADDR_W-1:0] periph_addr_i,
  input wire logic [ADDR_W-1:0] mem_addr_i,
  input wire logic [CNT_W-1:0] items_i,
  input wire logic start_i,
  // Channel status
  output logic busy_o,
  output logic done_o,
  output logic error_o,
  output logic [CNT_W-1:0] items_remaining_o,
  // AHB master
  output logic [ADDR_W-1:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [DATA_W-1:0] hwdata_o,
  input wire logic [DATA_W-1:0] hrdata_i,
  input wire logic hready_i,
  input wire logic hresp_i,
  // Register port access check
  input wire logic reg_sel_i,
  input wire logic [1:0] reg_htrans_i,
  input wire logic [2:0] reg_hsize_i,
  output logic reg_size_fault_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Address step for an item width
  function automatic logic [ADDR_W-1:0] step_of(input logic [1:0] w);
    case (w)
      WIDTH_BYTE: step_of = ADDR_W'(1);
      WIDTH_HALF: step_of = ADDR_W'(2);
      default: step_of = ADDR_W'(4);
    endcase
  endfunction

  // Keep only the low bits of an item that fit a width
  function automatic logic [DATA_W-1:0] fit(input logic [DATA_W-1:0] d, input logic [1:0] w);
    case (w)
      WIDTH_BYTE: fit = {24'h000000, d[7:0]};
      WIDTH_HALF: fit = {16'h0000, d[15:0]};
      default: fit = d;
    endcase
  endfunction

  // Pull the item off its byte lanes of the read bus, little endian
  function automatic logic [DATA_W-1:0] lane_extract(input logic [DATA_W-1:0] d,
                                                     input logic [1:0] a, input logic [1:0] w);
    lane_extract = fit(d >> {a, 3'h0}, w);
  endfunction

  // Copy narrow data onto every lane
  function automatic logic [DATA_W-1:0] replicate(input logic [DATA_W-1:0] d, input logic [1:0] w);
    case (w)
      WIDTH_BYTE: replicate = {4{d[7:0]}};
      WIDTH_HALF: replicate = {2{d[15:0]}};
      default: replicate = d;
    endcase
  endfunction

  typedef enum logic [2:0] {S_IDLE, S_RD_ADDR, S_RD_DATA, S_WR_WAIT, S_WR_ADDR, S_WR_DATA} dwa_state_t;

  dwa_state_t state_q, state_d;
  logic [1:0] src_w_q, src_w_d, dst_w_q, dst_w_d;
  logic src_step_q, src_step_d, dst_step_q, dst_step_d;
  logic [ADDR_W-1:0] src_addr_q, src_addr_d, dst_addr_q, dst_addr_d;
  logic [CNT_W-1:0] items_q, items_d;
  logic [ADDR_W-1:0] haddr_q, haddr_d;
  logic [1:0] htrans_q, htrans_d;
  logic hwrite_q, hwrite_d;
  logic [2:0] hsize_q, hsize_d;
  logic [DATA_W-1:0] hwdata_q, hwdata_d;
  logic busy_q, busy_d, done_q, done_d, error_q, error_d, fault_q, fault_d;
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [DATA_W-1:0] f_in_data, f_out_data;

  // ----------------------------------------------------------------
  // Item buffer between read and write phases
  // ----------------------------------------------------------------
  // Reads stall while it is full, so back-pressure reaches the read side
  dwa_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(f_in_valid),
    .in_ready_o(f_in_ready),
    .in_data_i(f_in_data),
    .out_valid_o(f_out_valid),
    .out_ready_i(f_out_ready),
    .out_data_o(f_out_data)
  );

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  // Single non-pipelined transfers keep one read strictly before one write
  always_comb begin
    state_d = state_q;
    src_w_d = src_w_q;
    dst_w_d = dst_w_q;
    src_step_d = src_step_q;
    dst_step_d = dst_step_q;
    src_addr_d = src_addr_q;
    dst_addr_d = dst_addr_q;
    items_d = items_q;
    haddr_d = haddr_q;
    htrans_d = htrans_q;
    hwrite_d = hwrite_q;
    hsize_d = hsize_q;
    hwdata_d = hwdata_q;
    busy_d = busy_q;
    done_d = 1'b0;
    error_d = error_q;
    f_in_valid = 1'b0;
    f_in_data = lane_extract(hrdata_i, src_addr_q[1:0], src_w_q);
    f_out_ready = 1'b0;
    case (state_q)
      S_IDLE: begin
        if (start_i && items_i != '0) begin
          // Separate settings for each side; direction picks source
          src_w_d = mem_to_periph_i ? mem_item_width_i : periph_item_width_i;
          dst_w_d = mem_to_periph_i ? periph_item_width_i : mem_item_width_i;
          src_step_d = mem_to_periph_i ? mem_addr_step_en_i : periph_addr_step_en_i;
          dst_step_d = mem_to_periph_i ? periph_addr_step_en_i : mem_addr_step_en_i;
          src_addr_d = mem_to_periph_i ? mem_addr_i : periph_addr_i;
          dst_addr_d = mem_to_periph_i ? periph_addr_i : mem_addr_i;
          items_d = items_i;
          busy_d = 1'b1;
          error_d = 1'b0;
          haddr_d = mem_to_periph_i ? mem_addr_i : periph_addr_i;
          hsize_d = (src_w_d == 2'h3) ? HSIZE_WORD : {1'b0, src_w_d}; // Spare code 3 goes out as a word
          hwrite_d = 1'b0;
          htrans_d = HTRANS_NONSEQ;
          state_d = S_RD_ADDR;
        end
      end
      S_RD_ADDR: begin
        if (hready_i) begin
          htrans_d = HTRANS_IDLE;
          state_d = S_RD_DATA;
        end
      end
      S_RD_DATA: begin
        if (hready_i && hresp_i != HRESP_OKAY) begin
          error_d = 1'b1;
          busy_d = 1'b0;
          state_d = S_IDLE;
        end else if (hready_i) begin
          // Source-width item, pulled off its lanes, held until the write phase
          f_in_valid = 1'b1;
          state_d = S_WR_WAIT;
        end
      end
      S_WR_WAIT: begin
        if (f_out_valid) begin
          haddr_d = dst_addr_q;
          hsize_d = (dst_w_q == 2'h3) ? HSIZE_WORD : {1'b0, dst_w_q};
          hwrite_d = 1'b1;
          htrans_d = HTRANS_NONSEQ;
          state_d = S_WR_ADDR;
        end
      end
      S_WR_ADDR: begin
        if (hready_i) begin
          f_out_ready = 1'b1;
          // Truncate then spread over unused lanes for size-blind slaves
          hwdata_d = replicate(fit(f_out_data, dst_w_q), dst_w_q);
          htrans_d = HTRANS_IDLE;
          state_d = S_WR_DATA;
        end
      end
      S_WR_DATA: begin
        if (hready_i && hresp_i != HRESP_OKAY) begin
          error_d = 1'b1;
          busy_d = 1'b0;
          hwrite_d = 1'b0;
          state_d = S_IDLE;
        end else if (hready_i) begin
          // Post-increment each side with stepping enabled by its own item size
          if (src_step_q) begin
            src_addr_d = src_addr_q + step_of(src_w_q);
          end
          if (dst_step_q) begin
            dst_addr_d = dst_addr_q + step_of(dst_w_q);
          end
          items_d = items_q - CNT_W'(1);
          hwrite_d = 1'b0;
          if (items_q == CNT_W'(1)) begin
            busy_d = 1'b0;
            done_d = 1'b1;
            state_d = S_IDLE;
          end else if (f_in_ready) begin
            haddr_d = src_step_q ? src_addr_q + step_of(src_w_q) : src_addr_q;
            hsize_d = (src_w_q == 2'h3) ? HSIZE_WORD : {1'b0, src_w_q};
            htrans_d = HTRANS_NONSEQ;
            state_d = S_RD_ADDR;
          end else begin
            state_d = S_WR_DATA;
          end
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= S_IDLE;
      src_w_q <= WIDTH_BYTE;
      dst_w_q <= WIDTH_BYTE;
      src_step_q <= 1'b0;
      dst_step_q <= 1'b0;
      src_addr_q <= ADDR_RST;
      dst_addr_q <= ADDR_RST;
      items_q <= '0;
      haddr_q <= ADDR_RST;
      htrans_q <= HTRANS_IDLE;
      hwrite_q <= 1'b0;
      hsize_q <= HSIZE_WORD;
      hwdata_q <= DATA_RST;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      error_q <= 1'b0;
    end else begin
      state_q <= state_d;
      src_w_q <= src_w_d;
      dst_w_q <= dst_w_d;
      src_step_q <= src_step_d;
      dst_step_q <= dst_step_d;
      src_addr_q <= src_addr_d;
      dst_addr_q <= dst_addr_d;
      items_q <= items_d;
      haddr_q <= haddr_d;
      htrans_q <= htrans_d;
      hwrite_q <= hwrite_d;
      hsize_q <= hsize_d;
      hwdata_q <= hwdata_d;
      busy_q <= busy_d;
      done_q <= done_d;
      error_q <= error_d;
    end
  end

  // ----------------------------------------------------------------
  // Register access width check
  // ----------------------------------------------------------------
  // Any active non-word access to our registers is flagged as a fault
  always_comb begin
    fault_d = reg_sel_i && reg_htrans_i[1] && reg_hsize_i != HSIZE_WORD;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_d;
    end
  end

  // Outputs straight from flops
  assign busy_o = busy_q;
  assign done_o = done_q;
  assign error_o = error_q;
  assign items_remaining_o = items_q;
  assign haddr_o = haddr_q;
  assign htrans_o = htrans_q;
  assign hwrite_o = hwrite_q;
  assign hsize_o = hsize_q;
  assign hwdata_o = hwdata_q;
  assign reg_size_fault_o = fault_q;
endmodule
`default_nettype wire

/* File: test/dwa_core_props.sv */
// Port checker for the DMA data path
`timescale 1ns/1ps
`default_nettype none
module dwa_core_props
  import dwa_pkg::*;
#(
  parameter int CNT_W = ITEM_CNT_W
) (
  // Clock, reset and channel
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic [CNT_W-1:0] items_i,
  input wire logic busy_o,
  input wire logic [CNT_W-1:0] items_remaining_o,
  // AHB master
  input wire logic [1:0] htrans_o,
  input wire logic hwrite_o,
  input wire logic [2:0] hsize_o,
  input wire logic [DATA_W-1:0] hwdata_o,
  input wire logic hready_i,
  // Register access check
  input wire logic reg_sel_i,
  input wire logic [1:0] reg_htrans_i,
  input wire logic [2:0] reg_hsize_i,
  input wire logic reg_size_fault_o
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic acc;
  logic bad_sz;
  logic last_wr_q;
  assign acc = htrans_o == HTRANS_NONSEQ && hready_i;
  assign bad_sz = reg_sel_i && reg_htrans_i[1] && reg_hsize_i != HSIZE_WORD;
  // Last accepted direction; a fresh run must open with a read
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) last_wr_q <= 1'b1;
    else if (!busy_o && start_i) last_wr_q <= 1'b1;
    else if (acc) last_wr_q <= hwrite_o;
  end
  sequence s_wr_acc;
    acc && hwrite_o;
  endsequence
  sequence s_wr_wait;
    s_wr_acc ##1 !hready_i;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_alt_dir: assert property (acc |-> hwrite_o != last_wr_q)
    else $error("read and write did not alternate");
  a_one_idle: assert property (acc |=> htrans_o == HTRANS_IDLE)
    else $error("transfers pipelined");
  a_start_read: assert property (!busy_o && start_i && items_i != 0 |=> busy_o && htrans_o == HTRANS_NONSEQ && !hwrite_o)
    else $error("run did not open with a read");
  a_byte_lanes: assert property ((s_wr_acc and (hsize_o == HSIZE_BYTE)) |=> hwdata_o == {4{hwdata_o[7:0]}})
    else $error("byte not copied to all lanes");
  a_half_lanes: assert property ((s_wr_acc and (hsize_o == HSIZE_HALF)) |=> hwdata_o == {2{hwdata_o[15:0]}})
    else $error("halfword not copied to both halves");
  a_data_hold: assert property (s_wr_wait |=> $stable(hwdata_o))
    else $error("write data moved during wait");
  a_fault_size: assert property (bad_sz |=> reg_size_fault_o)
    else $error("narrow register access not faulted");
  a_fault_quiet: assert property (!bad_sz |=> !reg_size_fault_o)
    else $error("fault without narrow access");
  a_count_step: assert property (busy_o && $past(busy_o) && $changed(items_remaining_o)
    |-> items_remaining_o == CNT_W'($past(items_remaining_o) - 1'b1))
    else $error("item count not stepped by one");
endmodule
bind dwa_core dwa_core_props #(.CNT_W(CNT_W)) dwa_core_props_i (.*);
`default_nettype wire

/* File: test/dwa_ahb_mem.sv */
// AHB slave memory that writes whole words, with wait states and error answer
`timescale 1ns/1ps
`default_nettype none
module dwa_ahb_mem (
  // Clock and controls
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic slow_i,
  input wire logic err_en_i,
  input wire logic [31:0] err_addr_i,
  // AHB slave
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hready_o,
  output logic hresp_o
);
  logic [31:0] mem [0:63];
  logic [67:0] log_q [$];
  logic dp_q, wr_q, wt_q, bad;
  logic [2:0] sz_q;
  logic [31:0] a_q, last_q;
  initial for (int i = 0; i < 64; i++) mem[i] = {8'(4*i+3), 8'(4*i+2), 8'(4*i+1), 8'(4*i)} ^ 32'ha5a5a5a5;
  // Error takes two cycles, the first with hready low
  assign bad = err_en_i && a_q == err_addr_i;
  assign hresp_o = dp_q && bad;
  assign hready_o = !(dp_q && (slow_i || bad) && !wt_q);
  // Outside a read data phase the bus shows junk, never the old word
  assign hrdata_o = (dp_q && !wr_q) ? mem[a_q[7:2]] : ~last_q;
  // Data phase tracking, logging, word-wide writes
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dp_q <= 1'b0;
      wt_q <= 1'b0;
    end else begin
      wt_q <= dp_q && !hready_o;
      if (hready_o) begin
        dp_q <= htrans_i[1];
        a_q <= haddr_i;
        wr_q <= hwrite_i;
        sz_q <= hsize_i;
      end
      if (dp_q && hready_o && !bad) begin
        log_q.push_back({wr_q, sz_q, a_q, wr_q ? hwdata_i : 32'h0});
        if (wr_q) mem[a_q[7:2]] <= hwdata_i;
        else last_q <= hrdata_o;
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/tb_dwa_core.sv */
// Testbench for the DMA data path
`timescale 1ns/1ps
`default_nettype none
module tb_dwa_core;
  import dwa_pkg::*;
  logic clk_i = 1'b0, resetn_i = 1'b0;
  logic [1:0] pw = 2'h0, mw = 2'h0, rht = 2'h0, htrans;
  logic pse = 1'b1, mse = 1'b1, m2p = 1'b0, start = 1'b0, rsel = 1'b0, slow = 1'b0, erren = 1'b0;
  logic [31:0] pa = 32'h0, ma = 32'h0, haddr, hwdata, hrdata;
  logic [15:0] items = 16'h0, irem;
  logic [2:0] rhs = 3'h0, hsize;
  logic busy, done, err, hwrite, hready, hresp, fault;
  int miscompares = 0, tests_run = 0;
  dwa_core dwa_core_i (.clk_i(clk_i), .resetn_i(resetn_i), .periph_item_width_i(pw), .mem_item_width_i(mw),
    .periph_addr_step_en_i(pse), .mem_addr_step_en_i(mse), .mem_to_periph_i(m2p), .periph_addr_i(pa),
    .mem_addr_i(ma), .items_i(items), .start_i(start), .busy_o(busy), .done_o(done), .error_o(err),
    .items_remaining_o(irem), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
    .hwdata_o(hwdata), .hrdata_i(hrdata), .hready_i(hready), .hresp_i(hresp), .reg_sel_i(rsel),
    .reg_htrans_i(rht), .reg_hsize_i(rhs), .reg_size_fault_o(fault));
  dwa_ahb_mem dwa_ahb_mem_i (.clk_i(clk_i), .resetn_i(resetn_i), .slow_i(slow), .err_en_i(erren),
    .err_addr_i(32'h80), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hrdata_o(hrdata), .hready_o(hready), .hresp_o(hresp));
  initial forever #2 clk_i = ~clk_i;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [67:0] e, input logic [67:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Source bytes: a memory byte holds its address xor a5
  function automatic logic [31:0] item(input logic [31:0] a, input logic [1:0] w);
    item = 32'h0;
    for (int j = 0; j < (1 << w); j++) item[8*j +: 8] = 8'(a + j) ^ 8'ha5;
  endfunction
  // One run, source at 0x0 and destination at 0x80, then its transfer log
  task automatic xfer(input logic [1:0] sw, dw, input logic dir, ss, ds, input logic [15:0] n);
    logic [31:0] s, d, v;
    @(posedge clk_i);
    pw <= dir ? dw : sw;
    mw <= dir ? sw : dw;
    pse <= dir ? ds : ss;
    mse <= dir ? ss : ds;
    m2p <= dir;
    pa <= dir ? 32'h80 : 32'h0;
    ma <= dir ? 32'h0 : 32'h80;
    items <= n;
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    // Let the sticky error of an earlier run clear before watching it
    @(negedge clk_i);
    for (int k = 0; k < 400 && done !== 1'b1 && err !== 1'b1; k++) @(negedge clk_i);
    if (erren) return;
    chk("done", 68'h1, 68'(done));
    chk("left", 68'h0, 68'(irem));
    for (int k = 0; k < n; k++) begin
      s = ss ? k << sw : 0;
      d = ds ? k << dw : 0;
      v = item(s, sw);
      v = (dw == 2'h0) ? {4{v[7:0]}} : (dw == 2'h1) ? {2{v[15:0]}} : v;
      chk("read", {2'b00, sw, s, 32'h0}, dwa_ahb_mem_i.log_q.pop_front());
      chk("write", {2'b10, dw, 32'h80 + d, v}, dwa_ahb_mem_i.log_q.pop_front());
    end
  endtask
  // ----------------------------------------
  // Sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(negedge clk_i);
    chk("idle", {ADDR_RST, DATA_RST, HTRANS_IDLE, 2'b00}, {haddr, hwdata, htrans, busy, fault});
    chk("reset", 68'({HSIZE_WORD, 19'h0}), 68'({hsize, hwrite, done, err, irem}));
    for (int i = 0; i < 9; i++) xfer(2'(i / 3), 2'(i % 3), 1'(i), 1'b1, 1'b1, 16'h4);
    slow <= 1'b1;
    xfer(2'h2, 2'h0, 1'b1, 1'b1, 1'b0, 16'h3);
    slow <= 1'b0;
    xfer(2'h0, 2'h1, 1'b0, 1'b0, 1'b1, 16'h2);
    @(posedge clk_i);
    erren <= 1'b1;
    xfer(2'h2, 2'h2, 1'b1, 1'b1, 1'b1, 16'h2);
    chk("error", 68'h2, {66'h0, err, busy});
    chk("reads", 68'h1, 68'(dwa_ahb_mem_i.log_q.size()));
    dwa_ahb_mem_i.log_q.delete();
    @(posedge clk_i);
    erren <= 1'b0;
    xfer(2'h1, 2'h2, 1'b0, 1'b1, 1'b1, 16'h1);
    chk("error", 68'h0, 68'(err));
    // Narrow, full and unselected register accesses
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i);
      rsel <= i[3];
      rht <= {i[2], 1'b0};
      rhs <= 3'(i[1:0]);
      @(posedge clk_i);
      @(negedge clk_i);
      chk("fault", 68'(i[3] && i[2] && i[1:0] != 2'h2), 68'(fault));
    end
    // Reset in mid-run drops the channel back to idle, then a fresh run works
    @(posedge clk_i);
    items <= 16'h4;
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b0;
    @(posedge clk_i);
    resetn_i <= 1'b1;
    @(negedge clk_i);
    chk("abort", 68'h0, 68'({busy, done, err, htrans, hwrite, irem}));
    dwa_ahb_mem_i.log_q.delete();
    xfer(2'h0, 2'h0, 1'b0, 1'b1, 1'b1, 16'h1);
    complete_run();
  end
endmodule
`default_nettype wire
